/* File: logic/lpsc_defs.svh */
// Constants of the low-power SDRAM command scheduler: timings, encodings.
// Assumes a 10 MHz controller clock; times are in nanoseconds, latencies RL and WL in clocks.
// Overview of operation
// RQ1: Activate after auto precharge waits tRP and tRC.
// RQ2: Device starts write auto precharge tWR after burst.
// RQ3: Read to precharge spacing uses tRTP formula.
// RQ4: Burst stop to precharge: read 1, write longer.
// RQ5: Activate after read auto precharge waits extra tRPpb.
// RQ6: No read or write to auto-precharged bank.
// RQ7: Write after read auto precharge waits turnaround.
// RQ8: Seamless reads or writes to other banks allowed.
// RQ9: Write to precharge spacing includes write recovery.
// RQ10: Activate after write auto precharge waits extra tRPpb.
// RQ11: Read after write auto precharge waits tWTR turnaround.
// RQ12: Precharges may follow each other every clock.
// RQ13: Precharge period counts from latest precharge of bank.
// RQ14: Never issue inside delays; never cut auto-precharge bursts.
// RQ15: Refresh opcode 100 on CA2..0, CA3 selects kind.
// RQ16: Per-bank refresh exists only on eight banks.
// RQ17: Per-bank refresh bank counter cycles 0 to 7.
// RQ18: Refresh bank counter zeroed on reset, self-refresh exit.
// RQ19: Controller tracks refresh bank and keeps it idle.
// RQ20: Per-bank refresh waits tRFCab, tRFCpb and tRP.
// RQ21: All-banks flag plus three bank bits select banks.
// RQ22: Separations use programmed or truncated burst length.
`ifndef LPSC_DEFS_SVH
`define LPSC_DEFS_SVH
`define LPSC_TCK_NS 100
`define LPSC_BL 8
`define LPSC_RL 3
`define LPSC_WL 1
`define LPSC_TRTP_NS 8
`define LPSC_TWR_NS 15
`define LPSC_TRPPB_NS 18
`define LPSC_TRPAB_NS 21
`define LPSC_TRC_NS 60
`define LPSC_TWTR_NS 8
`define LPSC_TDQSCKMAX_NS 6
`define LPSC_TRFCAB_NS 130
`define LPSC_TRFCPB_NS 60
`define LPSC_EIGHT_BANKS 1'b1
`define LPSC_NBANK 8
`define LPSC_OP_ACT 4'h2
`define LPSC_OP_RD 4'h5
`define LPSC_OP_WR 4'h1
`define LPSC_OP_PRE 4'hB
`define LPSC_OP_BST 4'h3
`define LPSC_OP_REF_BANK 4'h4
`define LPSC_OP_REF_ALL 4'hC
`define LPSC_ALLBANK_BIT 4
`define LPSC_BANK_LSB 7
`define LPSC_AUTOPRE_BIT 0
`endif

/* File: logic/lpsc_pkg.sv */
// Types shared by the low-power SDRAM command scheduler.
// Assumes the constants header is compiled alongside.
package lpsc_pkg;
   typedef enum logic [3:0] {
      CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA, CMD_BST,
      CMD_REF_BANK, CMD_REF_ALL, CMD_SYNC
   } lpsc_cmd_t;
endpackage

/* File: logic/lpsc_sched.sv */
// Command scheduler that drives a low-power DDR SDRAM command/address bus.
// Assumes a PHY serialises caRise and caFall onto the two clock halves.
`timescale 1ns/100ps
`include "lpsc_defs.svh"
module lpsc_sched
(
   input wire logic clk,
   input wire logic rst,
   input wire logic reqValid,
   input wire lpsc_pkg::lpsc_cmd_t reqCmd,
   input wire logic [2:0] reqBank,
   input wire logic reqAutoPre,
   output logic reqAck,
   output logic reqErr,
   output logic csN,
   output logic [9:0] caRise,
   output logic [9:0] caFall,
   output logic [2:0] refBank,
   output logic [7:0] bankOpen
);
   function automatic int ru(input int ns);
      int c;
      c = (ns + `LPSC_TCK_NS - 1) / `LPSC_TCK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic logic [7:0] ld(input logic [7:0] cur,
                                     input logic [7:0] sep);
      logic [7:0] d;
      d = (cur == 8'h00) ? 8'h00 : cur - 8'h01;
      return (d > sep - 8'h01) ? d : sep - 8'h01;
   endfunction

   function automatic logic [7:0] dec(input logic [7:0] cur);
      return (cur == 8'h00) ? 8'h00 : cur - 8'h01;
   endfunction

   localparam int RTPC = (ru(`LPSC_TRTP_NS) > 2) ? ru(`LPSC_TRTP_NS) : 2;
   localparam logic [7:0] SEAM = 8'(`LPSC_BL / 2);
   localparam logic [7:0] RDPRE = 8'(`LPSC_BL / 2 + RTPC - 2);
   localparam logic [7:0] RDAPACT = 8'(`LPSC_BL / 2 + RTPC - 2
                                       + ru(`LPSC_TRPPB_NS));
   localparam logic [7:0] RDAPWR = 8'(`LPSC_RL + `LPSC_BL / 2
                                      + ru(`LPSC_TDQSCKMAX_NS)
                                      - `LPSC_WL + 1);
   localparam logic [7:0] WRPRE = 8'(`LPSC_WL + `LPSC_BL / 2
                                     + ru(`LPSC_TWR_NS) + 1);
   localparam logic [7:0] WRAPACT = 8'(`LPSC_WL + `LPSC_BL / 2
                                       + ru(`LPSC_TWR_NS) + 1
                                       + ru(`LPSC_TRPPB_NS));
   localparam logic [7:0] WRAPRD = 8'(`LPSC_WL + `LPSC_BL / 2
                                      + ru(`LPSC_TWTR_NS) + 1);
   localparam logic [7:0] BSTWR = 8'(`LPSC_WL + ru(`LPSC_TWR_NS) + 1);
   localparam logic [7:0] RPPB = 8'(ru(`LPSC_TRPPB_NS));
   localparam logic [7:0] RPAB = 8'(ru(`LPSC_TRPAB_NS));
   localparam logic [7:0] RCC = 8'(ru(`LPSC_TRC_NS));
   localparam logic [7:0] RFCAB = 8'(ru(`LPSC_TRFCAB_NS));
   localparam logic [7:0] RFCPB = 8'(ru(`LPSC_TRFCPB_NS));

   logic [7:0] preW_q [`LPSC_NBANK];
   logic [7:0] actW_q [`LPSC_NBANK];
   logic [7:0] rdW_q, wrW_q, refW_q;
   logic [7:0] open_q;
   logic [2:0] refBank_q;
   logic [2:0] lastBank_q;
   logic lastWr_q, lastAutoPre_q, burstLive_q;
   logic reqAck_q, reqErr_q, csN_q;
   logic [9:0] caRise_q, caFall_q;
   logic legal, bad, take;
   logic allPre, allAct;
   logic [2:0] b;

   always_comb
   begin
      allPre = 1'b1;
      allAct = 1'b1;
      for (int i = 0; i < `LPSC_NBANK; i++)
      begin
         if (preW_q[i] != 8'h00)
            allPre = 1'b0;
         if (actW_q[i] != 8'h00)
            allAct = 1'b0;
      end
   end

   // Requests other than burst stop and sync are judged against the per-bank or global wait counters.
   always_comb
   begin
      b = reqBank;
      legal = 1'b0;
      bad = 1'b0;
      case (reqCmd)
         lpsc_pkg::CMD_ACT:
            legal = !open_q[b] && actW_q[b] == 8'h00; // [RQ1] [RQ13]
         lpsc_pkg::CMD_RD:
         begin
            bad = !open_q[b]; // [RQ6]
            legal = open_q[b] && rdW_q == 8'h00; // [RQ8] [RQ11]
         end
         lpsc_pkg::CMD_WR:
         begin
            bad = !open_q[b]; // [RQ6]
            legal = open_q[b] && wrW_q == 8'h00; // [RQ7] [RQ8]
         end
         lpsc_pkg::CMD_PRE:
            legal = preW_q[b] == 8'h00; // [RQ3] [RQ9] [RQ12]
         lpsc_pkg::CMD_PREA:
            legal = allPre; // [RQ3] [RQ9] [RQ12]
         lpsc_pkg::CMD_BST:
         begin
            bad = !burstLive_q || lastAutoPre_q; // [RQ14]
            legal = !bad;
         end
         lpsc_pkg::CMD_REF_BANK:
         begin
            bad = !`LPSC_EIGHT_BANKS; // [RQ16]
            legal = !bad && !open_q[refBank_q] // [RQ19]
                    && actW_q[refBank_q] == 8'h00 // [RQ20]
                    && refW_q == 8'h00; // [RQ20]
         end
         lpsc_pkg::CMD_REF_ALL:
            legal = open_q == 8'h00 && allAct && refW_q == 8'h00;
         lpsc_pkg::CMD_SYNC:
            legal = 1'b1;
         default:
            bad = 1'b1;
      endcase
   end

   assign take = reqValid && !reqAck_q && legal && !bad; // [RQ14]

   // Per-bank wait counters and open-row tracking.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         open_q <= 8'h00;
         for (int i = 0; i < `LPSC_NBANK; i++)
         begin
            preW_q[i] <= 8'h00;
            actW_q[i] <= 8'h00;
         end
      end
      else
      begin
         for (int i = 0; i < `LPSC_NBANK; i++)
         begin
            preW_q[i] <= dec(preW_q[i]);
            actW_q[i] <= dec(actW_q[i]);
            if (take && reqBank == 3'(i))
            begin
               case (reqCmd)
                  lpsc_pkg::CMD_ACT:
                  begin
                     open_q[i] <= 1'b1;
                     actW_q[i] <= ld(actW_q[i], RCC); // [RQ1]
                  end
                  lpsc_pkg::CMD_RD:
                  begin
                     preW_q[i] <= ld(preW_q[i], RDPRE); // [RQ3] [RQ22]
                     if (reqAutoPre)
                     begin
                        open_q[i] <= 1'b0; // [RQ6]
                        actW_q[i] <= ld(actW_q[i], RDAPACT); // [RQ5]
                     end
                  end
                  lpsc_pkg::CMD_WR:
                  begin
                     preW_q[i] <= ld(preW_q[i], WRPRE); // [RQ9] [RQ22]
                     if (reqAutoPre)
                     begin
                        open_q[i] <= 1'b0; // [RQ6]
                        actW_q[i] <= ld(actW_q[i], WRAPACT); // [RQ10]
                     end
                  end
                  lpsc_pkg::CMD_PRE:
                  begin
                     open_q[i] <= 1'b0;
                     actW_q[i] <= ld(actW_q[i], RPPB); // [RQ13]
                  end
                  default:
                  begin
                  end
               endcase
            end
            if (take && reqCmd == lpsc_pkg::CMD_PREA)
            begin
               open_q[i] <= 1'b0;
               actW_q[i] <= ld(actW_q[i], RPAB); // [RQ13]
            end
            // A burst stop shortens the burst, so the wait is replaced.
            if (take && reqCmd == lpsc_pkg::CMD_BST && lastBank_q == 3'(i))
               preW_q[i] <= lastWr_q ? BSTWR - 8'h01 : 8'h00; // [RQ4]
            if (take && reqCmd == lpsc_pkg::CMD_REF_BANK
                && refBank_q == 3'(i))
               actW_q[i] <= ld(actW_q[i], RFCPB); // [RQ20]
            if (take && reqCmd == lpsc_pkg::CMD_REF_ALL)
               actW_q[i] <= ld(actW_q[i], RFCAB);
         end
      end
   end

   // Bank-independent turnaround and refresh spacing.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdW_q <= 8'h00;
         wrW_q <= 8'h00;
         refW_q <= 8'h00;
      end
      else
      begin
         rdW_q <= dec(rdW_q);
         wrW_q <= dec(wrW_q);
         refW_q <= dec(refW_q);
         if (take && reqCmd == lpsc_pkg::CMD_RD)
         begin
            rdW_q <= ld(rdW_q, SEAM); // [RQ8]
            wrW_q <= ld(wrW_q, RDAPWR); // [RQ7]
         end
         if (take && reqCmd == lpsc_pkg::CMD_WR)
         begin
            wrW_q <= ld(wrW_q, SEAM); // [RQ8]
            rdW_q <= ld(rdW_q, WRAPRD); // [RQ11]
         end
         if (take && reqCmd == lpsc_pkg::CMD_REF_BANK)
            refW_q <= ld(refW_q, RFCPB); // [RQ20]
         if (take && reqCmd == lpsc_pkg::CMD_REF_ALL)
            refW_q <= ld(refW_q, RFCAB); // [RQ20]
      end
   end

   // Last burst, for burst-stop legality and its recovery time.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lastBank_q <= 3'h0;
         lastWr_q <= 1'b0;
         lastAutoPre_q <= 1'b0;
         burstLive_q <= 1'b0;
      end
      else if (take)
      begin
         if (reqCmd == lpsc_pkg::CMD_RD || reqCmd == lpsc_pkg::CMD_WR)
         begin
            lastBank_q <= reqBank;
            lastWr_q <= reqCmd == lpsc_pkg::CMD_WR;
            lastAutoPre_q <= reqAutoPre;
            burstLive_q <= 1'b1;
         end
         else if (reqCmd == lpsc_pkg::CMD_BST)
            burstLive_q <= 1'b0;
      end
   end

   // Host copy of the device's refresh bank counter.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         refBank_q <= 3'h0; // [RQ18]
      else if (take && reqCmd == lpsc_pkg::CMD_REF_BANK)
         refBank_q <= refBank_q + 3'h1; // [RQ17] [RQ19]
      else if (take && (reqCmd == lpsc_pkg::CMD_SYNC
                        || reqCmd == lpsc_pkg::CMD_REF_ALL))
         refBank_q <= 3'h0; // [RQ18]
   end

   // Command bus drive; deselect when nothing is issued.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         csN_q <= 1'b1;
         caRise_q <= 10'h000;
         caFall_q <= 10'h000;
         reqAck_q <= 1'b0;
         reqErr_q <= 1'b0;
      end
      else
      begin
         reqAck_q <= reqValid && !reqAck_q && (legal || bad);
         reqErr_q <= reqValid && !reqAck_q && bad;
         csN_q <= !(take && reqCmd != lpsc_pkg::CMD_SYNC);
         caRise_q <= 10'h000;
         caFall_q <= 10'h000;
         caRise_q[9:`LPSC_BANK_LSB] <= reqBank; // [RQ21]
         case (reqCmd)
            lpsc_pkg::CMD_ACT: caRise_q[3:0] <= `LPSC_OP_ACT;
            lpsc_pkg::CMD_RD, lpsc_pkg::CMD_WR:
            begin
               caRise_q[3:0] <= (reqCmd == lpsc_pkg::CMD_RD) ?
                                `LPSC_OP_RD : `LPSC_OP_WR;
               caFall_q[`LPSC_AUTOPRE_BIT] <= reqAutoPre; // [RQ2]
            end
            lpsc_pkg::CMD_PRE: caRise_q[3:0] <= `LPSC_OP_PRE;
            lpsc_pkg::CMD_PREA:
            begin
               caRise_q[3:0] <= `LPSC_OP_PRE;
               caRise_q[`LPSC_ALLBANK_BIT] <= 1'b1; // [RQ21]
            end
            lpsc_pkg::CMD_BST: caRise_q[3:0] <= `LPSC_OP_BST;
            lpsc_pkg::CMD_REF_BANK:
               caRise_q[3:0] <= `LPSC_OP_REF_BANK; // [RQ15]
            lpsc_pkg::CMD_REF_ALL:
               caRise_q[3:0] <= `LPSC_OP_REF_ALL; // [RQ15]
            default: caRise_q[3:0] <= 4'h0;
         endcase
      end
   end

   assign reqAck = reqAck_q;
   assign reqErr = reqErr_q;
   assign csN = csN_q;
   assign caRise = caRise_q;
   assign caFall = caFall_q;
   assign refBank = refBank_q;
   assign bankOpen = open_q;

   // Cycles since the latest read and write, for the checks below.
   logic [7:0] sinceRd_q, sinceWr_q;
   logic [2:0] rdBank_q, wrBank_q;
   logic rdAp_q, wrAp_q, rdCut_q, wrCut_q;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sinceRd_q <= 8'hFF;
         sinceWr_q <= 8'hFF;
         rdBank_q <= 3'h0;
         wrBank_q <= 3'h0;
         rdAp_q <= 1'b0;
         wrAp_q <= 1'b0;
         rdCut_q <= 1'b1;
         wrCut_q <= 1'b1;
      end
      else
      begin
         sinceRd_q <= (sinceRd_q == 8'hFF) ? 8'hFF : sinceRd_q + 8'h01;
         sinceWr_q <= (sinceWr_q == 8'hFF) ? 8'hFF : sinceWr_q + 8'h01;
         if (take && reqCmd == lpsc_pkg::CMD_RD)
         begin
            sinceRd_q <= 8'h01;
            rdBank_q <= reqBank;
            rdAp_q <= reqAutoPre;
            rdCut_q <= 1'b0;
         end
         if (take && reqCmd == lpsc_pkg::CMD_WR)
         begin
            sinceWr_q <= 8'h01;
            wrBank_q <= reqBank;
            wrAp_q <= reqAutoPre;
            wrCut_q <= 1'b0;
         end
         if (take && reqCmd == lpsc_pkg::CMD_BST)
         begin
            rdCut_q <= 1'b1;
            wrCut_q <= 1'b1;
         end
      end
   end

   a_pre_after_read: assert property ( // [RQ3]
      @(posedge clk) disable iff (rst)
      take && reqCmd == lpsc_pkg::CMD_PRE && reqBank == rdBank_q
      && !rdCut_q |-> sinceRd_q >= RDPRE)
      else $error("Precharge too soon after read.");
   a_pre_after_write: assert property ( // [RQ9]
      @(posedge clk) disable iff (rst)
      take && reqCmd == lpsc_pkg::CMD_PREA && !wrCut_q
      |-> sinceWr_q >= WRPRE)
      else $error("Precharge all too soon after write.");
   a_act_after_rdap: assert property ( // [RQ5]
      @(posedge clk) disable iff (rst)
      take && reqCmd == lpsc_pkg::CMD_ACT && rdAp_q
      && reqBank == rdBank_q |-> sinceRd_q >= RDAPACT)
      else $error("Activate too soon after read with auto precharge.");
   a_act_after_wrap: assert property ( // [RQ10]
      @(posedge clk) disable iff (rst)
      take && reqCmd == lpsc_pkg::CMD_ACT && wrAp_q
      && reqBank == wrBank_q |-> sinceWr_q >= WRAPACT)
      else $error("Activate too soon after write with auto precharge.");
   a_wr_after_rdap: assert property ( // [RQ7]
      @(posedge clk) disable iff (rst)
      take && reqCmd == lpsc_pkg::CMD_WR && rdAp_q
      |-> sinceRd_q >= RDAPWR)
      else $error("Write too soon after read with auto precharge.");
   a_rd_after_wrap: assert property ( // [RQ11]
      @(posedge clk) disable iff (rst)
      take && reqCmd == lpsc_pkg::CMD_RD && wrAp_q
      |-> sinceWr_q >= WRAPRD)
      else $error("Read too soon after write with auto precharge.");
   a_rw_open_bank: assert property ( // [RQ6]
      @(posedge clk) disable iff (rst)
      reqValid && !reqAck_q && (reqCmd == lpsc_pkg::CMD_RD
      || reqCmd == lpsc_pkg::CMD_WR) && !open_q[reqBank]
      |=> reqAck_q && reqErr_q && csN_q)
      else $error("Access to closed bank was not refused.");
   a_ref_bank_step: assert property ( // [RQ17]
      @(posedge clk) disable iff (rst)
      take && reqCmd == lpsc_pkg::CMD_REF_BANK && !open_q[refBank_q]
      |=> !csN_q && caRise_q[2:0] == 3'h4 && !caRise_q[3]
      && refBank_q == $past(refBank_q) + 3'h1)
      else $error("Per-bank refresh encoding or counter wrong.");
   a_ref_all_code: assert property ( // [RQ15]
      @(posedge clk) disable iff (rst)
      take && reqCmd == lpsc_pkg::CMD_REF_ALL
      |=> !csN_q && caRise_q[3:0] == `LPSC_OP_REF_ALL
      && refBank_q == 3'h0)
      else $error("All-bank refresh encoding or counter sync wrong.");
endmodule

/* File: sim/lpsc_dev_model.sv */
// Behavioural SDRAM device: decodes commands, keeps bank and refresh state.
// Assumes one command a cycle on the scheduler's registered CA halves.
`timescale 1ns/100ps
`include "lpsc_defs.svh"
module lpsc_dev_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic csN,
   input wire logic [9:0] caRise,
   input wire logic [9:0] caFall,
   input wire logic syncReq,
   output logic [2:0] devRefBank,
   output logic [7:0] nBad
);
   localparam int TCK = `LPSC_TCK_NS;
   localparam int RPPB = (`LPSC_TRPPB_NS + TCK - 1) / TCK;
   localparam int RPAB = (`LPSC_TRPAB_NS + TCK - 1) / TCK;
   localparam int RTP = (`LPSC_TRTP_NS + TCK - 1) / TCK;
   localparam int WRC = (`LPSC_TWR_NS + TCK - 1) / TCK;
   localparam int RDAP = `LPSC_BL / 2 + ((RTP > 2) ? RTP : 2) - 2 + RPPB;
   localparam int WRAP = `LPSC_WL + `LPSC_BL / 2 + WRC + 1 + RPPB;
   logic [7:0] isOpen;
   logic [2:0] bank;
   int cyc;
   int readyAt [8];
   assign bank = caRise[9:7];
   // A bad command bumps nBad and still takes effect, so later slips still show up.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cyc <= 0;
         isOpen <= 8'h00;
         devRefBank <= 3'h0;
         nBad <= 8'h00;
         foreach (readyAt[i]) readyAt[i] <= 0;
      end
      else
      begin
         cyc <= cyc + 1;
         if (syncReq)
            devRefBank <= 3'h0;
         if (!csN)
            case (caRise[3:0])
               `LPSC_OP_ACT:
               begin
                  if (isOpen[bank] || cyc < readyAt[bank])
                     nBad <= nBad + 8'h01;
                  isOpen[bank] <= 1'h1;
               end
               `LPSC_OP_RD, `LPSC_OP_WR:
               begin
                  if (!isOpen[bank])
                     nBad <= nBad + 8'h01;
                  if (caFall[`LPSC_AUTOPRE_BIT])
                  begin
                     isOpen[bank] <= 1'h0;
                     readyAt[bank] <= cyc +
                        ((caRise[3:0] == `LPSC_OP_RD) ? RDAP : WRAP);
                  end
               end
               `LPSC_OP_PRE:
                  if (caRise[`LPSC_ALLBANK_BIT])
                  begin
                     isOpen <= 8'h00;
                     foreach (readyAt[i]) readyAt[i] <= cyc + RPAB;
                  end
                  else
                  begin
                     isOpen[bank] <= 1'h0;
                     readyAt[bank] <= cyc + RPPB;
                  end
               `LPSC_OP_REF_BANK:
               begin
                  if (isOpen[devRefBank] || !`LPSC_EIGHT_BANKS)
                     nBad <= nBad + 8'h01;
                  devRefBank <= devRefBank + 3'h1;
               end
               `LPSC_OP_REF_ALL:
               begin
                  if (|isOpen)
                     nBad <= nBad + 8'h01;
                  devRefBank <= 3'h0;
               end
               default: ;
            endcase
      end
   end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the SDRAM command scheduler.
// Assumes the device model watches the same command bus.
`timescale 1ns/100ps
`include "lpsc_defs.svh"
module testbench;
   localparam int TCK = `LPSC_TCK_NS;
   localparam int HALF = `LPSC_BL / 2;
   localparam int RTP = (`LPSC_TRTP_NS + TCK - 1) / TCK;
   localparam int RPPB = (`LPSC_TRPPB_NS + TCK - 1) / TCK;
   localparam int WRC = (`LPSC_TWR_NS + TCK - 1) / TCK;
   localparam int WTR = (`LPSC_TWTR_NS + TCK - 1) / TCK;
   localparam int DQS = (`LPSC_TDQSCKMAX_NS + TCK - 1) / TCK;
   localparam int RDPRE = HALF + ((RTP > 2) ? RTP : 2) - 2;
   localparam int WRPRE = `LPSC_WL + HALF + WRC + 1;
   localparam int RDAPWR = `LPSC_RL + HALF + DQS - `LPSC_WL + 1;
   localparam int WRAPRD = `LPSC_WL + HALF + WTR + 1;
   localparam int BSTWR = `LPSC_WL + WRC + 1;
   localparam int RFCAB = (`LPSC_TRFCAB_NS + TCK - 1) / TCK;
   localparam int RFCPB = (`LPSC_TRFCPB_NS + TCK - 1) / TCK;
   logic clk, rst, reqValid, reqAutoPre, reqAck, reqErr, csN, syncReq;
   lpsc_pkg::lpsc_cmd_t reqCmd;
   logic [2:0] reqBank, refBank, devRefBank;
   logic [9:0] caRise, caFall;
   logic [7:0] bankOpen, nBad;
   int cyc = 0;
   int tAck = 0;
   int n_fail = 0;
   int checks = 0;

   lpsc_sched i_dut
   (
      .clk(clk), .rst(rst), .reqValid(reqValid), .reqCmd(reqCmd),
      .reqBank(reqBank), .reqAutoPre(reqAutoPre), .reqAck(reqAck),
      .reqErr(reqErr), .csN(csN), .caRise(caRise), .caFall(caFall),
      .refBank(refBank), .bankOpen(bankOpen)
   );
   lpsc_dev_model i_model
   (
      .clk(clk), .rst(rst), .csN(csN), .caRise(caRise), .caFall(caFall),
      .syncReq(syncReq), .devRefBank(devRefBank), .nBad(nBad)
   );

   always @(posedge clk) cyc <= cyc + 1;

   task automatic stop_test();
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t saw %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic geq(input int gap, input int lim);
      chk(10'(gap >= lim), 10'h001);
   endtask

   function automatic logic [3:0] opOf(input lpsc_pkg::lpsc_cmd_t c);
      case (c)
         lpsc_pkg::CMD_ACT: return `LPSC_OP_ACT;
         lpsc_pkg::CMD_RD: return `LPSC_OP_RD;
         lpsc_pkg::CMD_WR: return `LPSC_OP_WR;
         lpsc_pkg::CMD_BST: return `LPSC_OP_BST;
         lpsc_pkg::CMD_REF_BANK: return `LPSC_OP_REF_BANK;
         lpsc_pkg::CMD_REF_ALL: return `LPSC_OP_REF_ALL;
         default: return `LPSC_OP_PRE;
      endcase
   endfunction

   // Holds the request until the acknowledge, then checks the command word.
   task automatic issue(input lpsc_pkg::lpsc_cmd_t c, input logic [2:0] b,
      input logic ap, input logic bad);
      int n;
      n = 0;
      @(negedge clk);
      reqValid = 1'h1;
      reqCmd = c;
      reqBank = b;
      reqAutoPre = ap;
      while (reqAck !== 1'h1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      reqValid = 1'h0;
      tAck = cyc;
      chk(10'(reqAck), 10'h001);
      chk(10'(reqErr), 10'(bad));
      chk(10'(csN), 10'(bad || c == lpsc_pkg::CMD_SYNC));
      if (!bad && c != lpsc_pkg::CMD_SYNC)
      begin
         chk(10'(caRise[3:0]), 10'(opOf(c)));
         if (c inside {lpsc_pkg::CMD_ACT, lpsc_pkg::CMD_RD,
            lpsc_pkg::CMD_WR, lpsc_pkg::CMD_PRE})
            chk(10'(caRise[9:7]), 10'(b));
         if (c inside {lpsc_pkg::CMD_PRE, lpsc_pkg::CMD_PREA})
            chk(10'(caRise[4]), 10'(c == lpsc_pkg::CMD_PREA));
         if (c inside {lpsc_pkg::CMD_RD, lpsc_pkg::CMD_WR})
            chk(10'(caFall[0]), 10'(ap));
      end
   endtask

   task automatic t_read();
      int t0;
      // Straight after reset no burst is running, so a burst stop is refused.
      issue(lpsc_pkg::CMD_BST, 3'h0, 1'h0, 1'h1);
      issue(lpsc_pkg::CMD_ACT, 3'h3, 1'h0, 1'h0);
      chk(10'(bankOpen[3]), 10'h001);
      issue(lpsc_pkg::CMD_ACT, 3'h4, 1'h0, 1'h0);
      issue(lpsc_pkg::CMD_RD, 3'h3, 1'h1, 1'h0);
      t0 = tAck;
      issue(lpsc_pkg::CMD_RD, 3'h3, 1'h0, 1'h1);
      issue(lpsc_pkg::CMD_ACT, 3'h3, 1'h0, 1'h0);
      geq(tAck - t0, RDPRE + RPPB);
      issue(lpsc_pkg::CMD_RD, 3'h4, 1'h1, 1'h0);
      t0 = tAck;
      issue(lpsc_pkg::CMD_BST, 3'h0, 1'h0, 1'h1);
      issue(lpsc_pkg::CMD_RD, 3'h3, 1'h0, 1'h0);
      chk(10'(tAck - t0), 10'(HALF));
      issue(lpsc_pkg::CMD_WR, 3'h3, 1'h0, 1'h0);
      geq(tAck - t0, RDAPWR);
      t0 = tAck;
      issue(lpsc_pkg::CMD_PRE, 3'h3, 1'h0, 1'h0);
      geq(tAck - t0, WRPRE);
   endtask

   task automatic t_write();
      int t0, t1;
      issue(lpsc_pkg::CMD_ACT, 3'h1, 1'h0, 1'h0);
      issue(lpsc_pkg::CMD_ACT, 3'h2, 1'h0, 1'h0);
      issue(lpsc_pkg::CMD_WR, 3'h1, 1'h1, 1'h0);
      t0 = tAck;
      issue(lpsc_pkg::CMD_WR, 3'h2, 1'h0, 1'h0);
      chk(10'(tAck - t0), 10'(HALF));
      issue(lpsc_pkg::CMD_WR, 3'h1, 1'h0, 1'h1);
      issue(lpsc_pkg::CMD_RD, 3'h2, 1'h0, 1'h0);
      geq(tAck - t0, WRAPRD);
      t1 = tAck;
      issue(lpsc_pkg::CMD_ACT, 3'h1, 1'h0, 1'h0);
      geq(tAck - t0, WRPRE + RPPB);
      issue(lpsc_pkg::CMD_PRE, 3'h2, 1'h0, 1'h0);
      geq(tAck - t1, RDPRE);
      t0 = tAck;
      issue(lpsc_pkg::CMD_PREA, 3'h0, 1'h0, 1'h0);
      geq(tAck - t0, 1);
      chk(10'(bankOpen), 10'h000);
   endtask

   task automatic t_bst();
      int t0;
      issue(lpsc_pkg::CMD_ACT, 3'h0, 1'h0, 1'h0);
      issue(lpsc_pkg::CMD_RD, 3'h0, 1'h0, 1'h0);
      issue(lpsc_pkg::CMD_BST, 3'h0, 1'h0, 1'h0);
      t0 = tAck;
      issue(lpsc_pkg::CMD_PRE, 3'h0, 1'h0, 1'h0);
      geq(tAck - t0, 1);
      issue(lpsc_pkg::CMD_ACT, 3'h0, 1'h0, 1'h0);
      issue(lpsc_pkg::CMD_WR, 3'h0, 1'h0, 1'h0);
      issue(lpsc_pkg::CMD_BST, 3'h0, 1'h0, 1'h0);
      t0 = tAck;
      issue(lpsc_pkg::CMD_PRE, 3'h0, 1'h0, 1'h0);
      geq(tAck - t0, BSTWR);
   endtask

   task automatic t_ref();
      int t0;
      issue(lpsc_pkg::CMD_PREA, 3'h0, 1'h0, 1'h0);
      issue(lpsc_pkg::CMD_REF_ALL, 3'h0, 1'h0, 1'h0);
      t0 = tAck;
      for (int i = 0; i < 9; i++)
      begin
         @(negedge clk);
         chk(10'(refBank), 10'(i % 8));
         chk(10'(refBank), 10'(devRefBank));
         issue(lpsc_pkg::CMD_REF_BANK, 3'h0, 1'h0, 1'h0);
         geq(tAck - t0, (i == 0) ? RFCAB : RFCPB);
         t0 = tAck;
      end
      issue(lpsc_pkg::CMD_SYNC, 3'h0, 1'h0, 1'h0);
      syncReq = 1'h1;
      @(negedge clk);
      syncReq = 1'h0;
      chk(10'(refBank), 10'h000);
   endtask

   initial
   begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      n_fail++;
      stop_test();
   end

   initial
   begin
      rst = 1'h1;
      reqValid = 1'h0;
      reqCmd = lpsc_pkg::CMD_SYNC;
      reqBank = 3'h0;
      reqAutoPre = 1'h0;
      syncReq = 1'h0;
      repeat (5) @(negedge clk);
      rst = 1'h0;
      chk(10'(csN), 10'h001);
      chk(10'(refBank), 10'h000);
      chk(10'(bankOpen), 10'h000);
      t_read();
      t_write();
      t_bst();
      t_ref();
      chk(10'(nBad), 10'h000);
      stop_test();
   end
endmodule
